// ---- hw/hpp_host_port.sv ----
// Host microprocessor port: strobe decode, indirect access, ready handshake, fault ORs
//
// Function
// - Low master reset returns everything except the storage to initial state
// - Address captured under address latch strobe
// - Accesses honoured only while chip select low
// - First strobe: read strobe or data strobe
// - Second strobe: write strobe or direction select
// - One handshake output: ready or transfer acknowledge
// - Handshake only pulled low or released
// - Timing fault is OR of clock-error flags only
// - Any fault is OR of all error flags
// - Eight data bits, two address bits, selectable mode
// - Internal storage reached indirectly via location registers
`timescale 1ns/1ps
`include "hpp_map.svh"
module hpp_host_port
    import hpp_pkg::*;
#(
    parameter int ACC_CYCLES = `HPP_ACC_CYCLES,
    parameter int MEM_DEPTH  = `HPP_MEM_DEPTH
) (
    // Clock and reset
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_resetn,
    // Bus mode strap
    input  wire hpp_pkg::hpp_mode_e        i_mode,
    // Host bus
    input  wire logic [`HPP_ADDR_W-1:0]    i_addr,
    input  wire logic                      i_addr_latch,
    input  wire logic                      i_chip_sel_n,
    input  wire logic                      i_strobe1_n,
    input  wire logic                      i_strobe2_n,
    input  wire logic [`HPP_DATA_W-1:0]    i_data,
    output logic      [`HPP_DATA_W-1:0]    o_data,
    output logic                           o_data_oe,
    output logic                           o_ready_o,
    output logic                           o_ready_oe,
    // Error flag sources
    input  wire logic [`HPP_ERR_W-1:0]     i_clk_err_set,
    input  wire logic [`HPP_ERR_W-1:0]     i_sys_err_set,
    // Fault summaries
    output logic                           o_timing_fault_out,
    output logic                           o_any_fault_out
);
    import hpp_pkg::*;

    localparam int CW = $clog2(ACC_CYCLES + 1);
    localparam int AW = $clog2(MEM_DEPTH);

    // All host pins arrive asynchronously
    logic [`HPP_ADDR_W-1:0] addr_s;
    logic [`HPP_DATA_W-1:0] data_s;
    logic                   ale_s, cs_n_s, st1_n_s, st2_n_s;

    hpp_sync #(.W(`HPP_ADDR_W + `HPP_DATA_W + 4),
               .RST({{(`HPP_ADDR_W + `HPP_DATA_W){1'b0}}, 4'h7})) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_pin     ({i_addr, i_data, i_addr_latch, i_chip_sel_n, i_strobe1_n, i_strobe2_n}),
        .o_lvl     ({addr_s, data_s, ale_s, cs_n_s, st1_n_s, st2_n_s})
    );

    // Mode strap caught after reset release
    hpp_mode_e mode_q, mode_d;
    logic      mode_done_q, mode_done_d;

    hpp_state_e             st_q, st_d;
    logic [`HPP_ADDR_W-1:0] alat_q, alat_d;
    logic [`HPP_LOC_W-1:0]  loc_q, loc_d;
    logic [CW-1:0]          cnt_q, cnt_d;
    logic                   is_wr_q, is_wr_d;
    logic [`HPP_DATA_W-1:0] rd_q, rd_d;
    logic                   oe_q, oe_d;
    logic                   rdy_oe_q, rdy_oe_d;
    logic [`HPP_ERR_W-1:0]  clk_err_q, clk_err_d, sys_err_q, sys_err_d;
    logic                   tf_q, tf_d, af_q, af_d;
    logic [`HPP_DATA_W-1:0] mem [MEM_DEPTH];
    logic                   mem_we;

    logic req, wr_req;

    always_comb begin
        req    = 1'b0;
        wr_req = 1'b0;
        if (!cs_n_s) begin
            if (mode_q == HPP_MODE_STROBE_PAIR) begin
                req    = !st1_n_s || !st2_n_s;
                wr_req = !st2_n_s;
            end else begin
                req    = !st1_n_s;
                wr_req = !st2_n_s;
            end
        end
    end

    always_comb begin
        mode_d      = mode_q;
        mode_done_d = 1'b1;
        if (!mode_done_q) begin
            mode_d = i_mode;
        end
        alat_d     = alat_q;
        if (ale_s) begin
            alat_d = addr_s;
        end
        st_d     = st_q;
        cnt_d    = cnt_q;
        is_wr_d  = is_wr_q;
        loc_d    = loc_q;
        rd_d     = rd_q;
        oe_d     = oe_q;
        rdy_oe_d = rdy_oe_q;
        mem_we   = 1'b0;
        clk_err_d = clk_err_q | i_clk_err_set;
        sys_err_d = sys_err_q | i_sys_err_set;
        case (st_q)
            HPP_IDLE: begin
                oe_d = 1'b0;
                // Data strobe mode holds acknowledge released between cycles
                rdy_oe_d = 1'b0;
                if (req) begin
                    st_d    = HPP_WAIT;
                    cnt_d   = CW'(ACC_CYCLES);
                    is_wr_d = wr_req;
                    // Strobe-pair ready goes low while the access is pending
                    if (mode_q == HPP_MODE_STROBE_PAIR) begin
                        rdy_oe_d = 1'b1;
                    end
                end
            end
            HPP_WAIT: begin
                if (!req) begin
                    st_d     = HPP_IDLE;
                    rdy_oe_d = 1'b0;
                end else if (cnt_q > CW'(1)) begin
                    cnt_d = cnt_q - CW'(1);
                end else begin
                    st_d = HPP_ACK;
                    if (is_wr_q) begin
                        case (alat_q)
                            `HPP_ADDR_LOC_LO: loc_d[7:0]  = data_s;
                            `HPP_ADDR_LOC_HI: loc_d[15:8] = data_s;
                            `HPP_ADDR_DATA:   mem_we      = 1'b1;
                            default: begin
                                // Clear wins only where no new event arrives
                                if (data_s[`HPP_CTRL_CLR_CLK]) begin
                                    clk_err_d = i_clk_err_set;
                                end
                                if (data_s[`HPP_CTRL_CLR_SYS]) begin
                                    sys_err_d = i_sys_err_set;
                                end
                            end
                        endcase
                    end else begin
                        case (alat_q)
                            `HPP_ADDR_LOC_LO: rd_d = loc_q[7:0];
                            `HPP_ADDR_LOC_HI: rd_d = loc_q[15:8];
                            `HPP_ADDR_DATA:   rd_d = mem[loc_q[AW-1:0]];
                            default:          rd_d = clk_err_q | sys_err_q;
                        endcase
                        oe_d = 1'b1;
                    end
                    // Ready released in strobe-pair; acknowledge pulled in data-strobe
                    rdy_oe_d = (mode_q == HPP_MODE_DATA_STROBE);
                end
            end
            HPP_ACK: begin
                // Host keeps strobe until handshake seen, so wait for its release
                if (!req) begin
                    st_d     = HPP_HOLD;
                    oe_d     = 1'b0;
                    rdy_oe_d = 1'b0;
                    if (is_wr_q && alat_q == `HPP_ADDR_DATA) begin
                        loc_d = loc_q + `HPP_LOC_W'(1);
                    end
                    if (!is_wr_q && alat_q == `HPP_ADDR_DATA) begin
                        loc_d = loc_q + `HPP_LOC_W'(1);
                    end
                end
            end
            HPP_HOLD: begin
                st_d = HPP_IDLE;
            end
            default: begin
                st_d = HPP_IDLE;
            end
        endcase
        tf_d = |clk_err_q;
        af_d = |clk_err_q || |sys_err_q;
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_q      <= HPP_MODE_STROBE_PAIR;
            mode_done_q <= 1'b0;
            alat_q      <= '0;
            st_q        <= HPP_IDLE;
            cnt_q       <= '0;
            is_wr_q     <= 1'b0;
            loc_q       <= '0;
            rd_q        <= '0;
            oe_q        <= 1'b0;
            rdy_oe_q    <= 1'b0;
            clk_err_q   <= '0;
            sys_err_q   <= '0;
            tf_q        <= 1'b0;
            af_q        <= 1'b0;
        end else begin
            mode_q      <= mode_d;
            mode_done_q <= mode_done_d;
            alat_q      <= alat_d;
            st_q        <= st_d;
            cnt_q       <= cnt_d;
            is_wr_q     <= is_wr_d;
            loc_q       <= loc_d;
            rd_q        <= rd_d;
            oe_q        <= oe_d;
            rdy_oe_q    <= rdy_oe_d;
            clk_err_q   <= clk_err_d;
            sys_err_q   <= sys_err_d;
            tf_q        <= tf_d;
            af_q        <= af_d;
        end
    end

    // Storage has no reset; contents are undefined until written
    always_ff @(posedge i_clk_sys) begin
        if (mem_we) begin
            mem[loc_q[AW-1:0]] <= data_s;
        end
    end

    assign o_data             = rd_q;
    assign o_data_oe          = oe_q;
    assign o_ready_o          = 1'b0;
    assign o_ready_oe         = rdy_oe_q;
    assign o_timing_fault_out = tf_q;
    assign o_any_fault_out    = af_q;
endmodule

// ---- hw/hpp_map.svh ----
// Constants for the host processor port: addresses, field positions, timing counts
`ifndef HPP_MAP_SVH
`define HPP_MAP_SVH
`define HPP_DATA_W        8
`define HPP_ADDR_W        2
`define HPP_ERR_W         8
`define HPP_ADDR_LOC_LO   2'h0
`define HPP_ADDR_LOC_HI   2'h1
`define HPP_ADDR_DATA     2'h2
`define HPP_ADDR_CTRL     2'h3
`define HPP_CTRL_CLR_CLK  0
`define HPP_CTRL_CLR_SYS  1
`define HPP_ACC_TIME_NS   200
`define HPP_CLK_PERIOD_NS 100
`define HPP_ACC_CYCLES    ((`HPP_ACC_TIME_NS + `HPP_CLK_PERIOD_NS - 1) / `HPP_CLK_PERIOD_NS)
`define HPP_LOC_W         16
`define HPP_MEM_DEPTH     256
`endif

// ---- hw/hpp_pkg.sv ----
// Types for the host processor port
package hpp_pkg;
    typedef enum logic {
        HPP_MODE_STROBE_PAIR,
        HPP_MODE_DATA_STROBE
    } hpp_mode_e;
    typedef enum logic [1:0] {
        HPP_IDLE,
        HPP_WAIT,
        HPP_ACK,
        HPP_HOLD
    } hpp_state_e;
    typedef logic [7:0] hpp_byte_t;
endpackage

// ---- hw/hpp_sync.sv ----
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module hpp_sync #(
    parameter int         W     = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_resetn,
    // Pin side
    input  wire logic [W-1:0] i_pin,
    // Filtered level
    output logic      [W-1:0] o_lvl
);
    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
    logic [W-1:0] lvl_d;
    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_q  <= RST;
            s2_q  <= RST;
            s3_q  <= RST;
            lvl_q <= RST;
        end else begin
            s1_q  <= i_pin;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end
    assign o_lvl = lvl_q;
endmodule

// ---- verif/hpp_host_model.sv ----
// Host microprocessor model on the 8-bit parallel bus
`timescale 1ns/1ps
module hpp_host_model (
    // Clock and mode
    input  wire logic               i_clk_sys,
    input  wire hpp_pkg::hpp_mode_e i_mode,
    // Bus
    input  wire logic               i_ready,
    input  wire hpp_pkg::hpp_byte_t i_data,
    output logic [1:0]              o_addr,
    output logic                    o_addr_latch,
    output logic                    o_chip_sel_n,
    output logic                    o_strobe1_n,
    output logic                    o_strobe2_n,
    output hpp_pkg::hpp_byte_t      o_data,
    output logic                    o_data_oe
);
    import hpp_pkg::*;
    initial begin
        {o_addr, o_addr_latch, o_data, o_data_oe} = '0;
        {o_chip_sel_n, o_strobe1_n, o_strobe2_n} = 3'h7;
    end
    task automatic access(input logic wr, input logic sel, input logic [1:0] a,
                          input hpp_byte_t wd, output hpp_byte_t rd, output logic ok);
        logic low;
        low = 1'b0;
        ok = 1'b0;
        @(posedge i_clk_sys) #1;
        o_addr = a;
        o_addr_latch = 1'b1;
        repeat (6) @(posedge i_clk_sys) #1;
        o_addr_latch = 1'b0;
        repeat (6) @(posedge i_clk_sys) #1;
        o_chip_sel_n = !sel;
        o_data = wd;
        o_data_oe = wr;
        o_strobe2_n = !wr;
        o_strobe1_n = (i_mode == HPP_MODE_STROBE_PAIR) ? wr : 1'b0;
        // Pair mode: not-ready low first, then let go; data-strobe: acknowledge low
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge i_clk_sys) #1;
            low = low | !i_ready;
            ok = (i_mode == HPP_MODE_STROBE_PAIR) ? (low && i_ready) : !i_ready;
        end
        rd = i_data;
        {o_chip_sel_n, o_strobe1_n, o_strobe2_n} = 3'h7;
        o_data_oe = 1'b0;
        repeat (8) @(posedge i_clk_sys);
    endtask
endmodule

// ---- verif/hpp_host_port_checker.sv ----
// Port-level assertions for the host processor port
`timescale 1ns/1ps
`include "hpp_map.svh"
module hpp_host_port_checker (
    // Clock and reset
    input wire logic                  i_clk_sys,
    input wire logic                  i_resetn,
    // Watched pins
    input wire logic                  i_chip_sel_n,
    input wire logic                  o_data_oe,
    input wire logic                  o_ready_o,
    input wire logic                  o_ready_oe,
    input wire logic [`HPP_ERR_W-1:0] i_clk_err_set,
    input wire logic [`HPP_ERR_W-1:0] i_sys_err_set,
    input wire logic                  o_timing_fault_out,
    input wire logic                  o_any_fault_out
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    // Cycles since chip select went high; the pin sync makes the port lag it
    logic [3:0] cs_idle_q;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn)
            cs_idle_q <= 4'hf;
        else if (!i_chip_sel_n)
            cs_idle_q <= 4'h0;
        else if (cs_idle_q != 4'hf)
            cs_idle_q <= cs_idle_q + 4'h1;
    end
    AST_RESET_QUIET: assert property ($rose(i_resetn) |-> !o_ready_oe && !o_data_oe && !o_any_fault_out)
        else $error("outputs active after reset");
    AST_NEVER_HIGH: assert property (o_ready_o == 1'b0)
        else $error("handshake pin driven high");
    AST_IDLE_RELEASED: assert property (cs_idle_q == 4'hf |-> !o_ready_oe && !o_data_oe)
        else $error("port active without chip select");
    AST_ACK_NEEDS_CS: assert property ($rose(o_ready_oe) |-> cs_idle_q < 4'h8)
        else $error("handshake without chip select");
    // Flags take one edge and the summaries one more, so outputs trail a set by two
    AST_CLK_FAULT_SET: assert property (|i_clk_err_set |-> ##2 o_timing_fault_out)
        else $error("timing fault missed");
    AST_ANY_FAULT_SET: assert property (|(i_clk_err_set | i_sys_err_set) |-> ##2 o_any_fault_out)
        else $error("any fault missed");
    AST_CLK_FAULT_CAUSE: assert property ($rose(o_timing_fault_out) |-> $past(i_clk_err_set, 2) != '0)
        else $error("timing fault without clock flag");
    AST_ANY_FAULT_CAUSE: assert property ($rose(o_any_fault_out) |->
        ($past(i_clk_err_set, 2) != '0) || ($past(i_sys_err_set, 2) != '0))
        else $error("any fault without flag");
    AST_RELEASE_AFTER_CS: assert property ($rose(i_chip_sel_n) |-> ##[1:8] (!o_ready_oe && !o_data_oe))
        else $error("port still active after chip select release");
    AST_FAULT_NESTING: assert property (o_timing_fault_out |-> o_any_fault_out)
        else $error("timing fault outside any fault");
endmodule

bind hpp_host_port hpp_host_port_checker i_chk (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_chip_sel_n(i_chip_sel_n),
    .o_data_oe(o_data_oe), .o_ready_o(o_ready_o), .o_ready_oe(o_ready_oe),
    .i_clk_err_set(i_clk_err_set), .i_sys_err_set(i_sys_err_set),
    .o_timing_fault_out(o_timing_fault_out), .o_any_fault_out(o_any_fault_out));

// ---- verif/testbench.sv ----
// Self-checking testbench for the host processor port
`timescale 1ns/1ps
`include "hpp_map.svh"
module testbench;
    import hpp_pkg::*;
    logic       i_clk_sys = 1'b0;
    logic       i_resetn  = 1'b0;
    hpp_mode_e  mode      = HPP_MODE_STROBE_PAIR;
    logic [1:0] addr;
    logic       ale, cs_n, s1_n, s2_n, h_oe, d_oe, rdy_o, rdy_oe, tf, af;
    hpp_byte_t  h_data, d_data, bus;
    logic [7:0] clk_set   = '0;
    logic [7:0] sys_set   = '0;
    int         errors    = 0;
    int         n_tests   = 0;
    // Board pull-ups on handshake and data lines
    wire        ready     = rdy_oe ? rdy_o : 1'b1;
    assign bus = d_oe ? d_data : (h_oe ? h_data : 8'hff);
    always #50 i_clk_sys = ~i_clk_sys;
    hpp_host_port i_dut (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_mode(mode), .i_addr(addr),
        .i_addr_latch(ale), .i_chip_sel_n(cs_n), .i_strobe1_n(s1_n), .i_strobe2_n(s2_n),
        .i_data(bus), .o_data(d_data), .o_data_oe(d_oe), .o_ready_o(rdy_o),
        .o_ready_oe(rdy_oe), .i_clk_err_set(clk_set), .i_sys_err_set(sys_set),
        .o_timing_fault_out(tf), .o_any_fault_out(af));
    hpp_host_model i_host (
        .i_clk_sys(i_clk_sys), .i_mode(mode), .i_ready(ready), .i_data(bus), .o_addr(addr),
        .o_addr_latch(ale), .o_chip_sel_n(cs_n), .o_strobe1_n(s1_n), .o_strobe2_n(s2_n),
        .o_data(h_data), .o_data_oe(h_oe));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic do_reset(input hpp_mode_e m);
        @(posedge i_clk_sys) #1;
        i_resetn = 1'b0;
        mode = m;
        repeat (16) @(posedge i_clk_sys) #1;
        chk("reset outputs", {4'h0, rdy_oe, d_oe, tf, af}, 8'h00);
        i_resetn = 1'b1;
        repeat (4) @(posedge i_clk_sys);
    endtask
    task automatic acc(input logic wr, input logic [1:0] a, input hpp_byte_t wd,
                       output hpp_byte_t rd);
        logic ok;
        i_host.access(wr, 1'b1, a, wd, rd, ok);
        chk("handshake", {7'h0, ok}, 8'h01);
    endtask
    task automatic pulse(input logic [7:0] c, input logic [7:0] s);
        @(posedge i_clk_sys) #1;
        {clk_set, sys_set} = {c, s};
        @(posedge i_clk_sys) #1;
        {clk_set, sys_set} = '0;
        repeat (3) @(posedge i_clk_sys) #1;
    endtask
    // Top three store bytes, written then read back after relocating
    task automatic t_mem(input hpp_mode_e m);
        hpp_byte_t rd;
        do_reset(m);
        acc(1'b1, `HPP_ADDR_LOC_HI, 8'h00, rd);
        for (int p = 0; p < 2; p++) begin
            acc(1'b1, `HPP_ADDR_LOC_LO, 8'hfd, rd);
            for (int i = 0; i < 3; i++) begin
                acc(p == 0, `HPP_ADDR_DATA, 8'ha5 ^ i[7:0], rd);
                if (p == 1)
                    chk("store byte", rd, 8'ha5 ^ i[7:0]);
            end
        end
        // Six data accesses from 00fd then 01fd leave the location at 0200
        acc(1'b0, `HPP_ADDR_LOC_LO, 8'h00, rd);
        chk("location low", rd, 8'h00);
        acc(1'b0, `HPP_ADDR_LOC_HI, 8'h00, rd);
        chk("location high", rd, 8'h02);
    endtask
    task automatic t_refuse();
        hpp_byte_t rd;
        logic      ok;
        acc(1'b1, `HPP_ADDR_LOC_LO, 8'hfd, rd);
        i_host.access(1'b1, 1'b0, `HPP_ADDR_DATA, 8'h3c, rd, ok);
        chk("deselected access", {7'h0, ok}, 8'h00);
        acc(1'b0, `HPP_ADDR_DATA, 8'h00, rd);
        chk("byte kept", rd, 8'ha5);
    endtask
    task automatic t_fault();
        hpp_byte_t rd;
        pulse(8'h00, 8'h04);
        chk("timing fault", {7'h0, tf}, 8'h00);
        chk("any fault", {7'h0, af}, 8'h01);
        acc(1'b0, `HPP_ADDR_CTRL, 8'h00, rd);
        chk("flag summary", rd, 8'h04);
        pulse(8'h80, 8'h00);
        chk("timing fault", {7'h0, tf}, 8'h01);
        acc(1'b1, `HPP_ADDR_CTRL, 8'h01, rd);
        chk("faults after clock clear", {6'h0, tf, af}, 8'h01);
        acc(1'b1, `HPP_ADDR_CTRL, 8'h02, rd);
        chk("faults after clear", {6'h0, tf, af}, 8'h00);
        pulse(8'h01, 8'h00);
        chk("clock flag sets both", {6'h0, tf, af}, 8'h03);
    endtask
    initial begin
        t_mem(HPP_MODE_STROBE_PAIR);
        t_fault();
        t_mem(HPP_MODE_DATA_STROBE);
        t_refuse();
        complete_run();
    end
    initial begin
        #2000000;
        errors++;
        complete_run();
    end
endmodule
